// ---- hw/lrc_pkg.sv ----
// Package with register map, field layout and voltage coding for the regulator control bank.
package lrc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] REG_FIVE_OFS  = 8'h32;
  localparam logic [7:0] REG_EIGHT_OFS = 8'h33;
  localparam logic [7:0] REG_SEVEN_OFS = 8'h34;
  localparam logic [7:0] REG_SIX_OFS   = 8'h35;
  localparam logic [7:0] REG_FOUR_OFS  = 8'h36;
  localparam int         NUM_REGS      = 5;

  // ==========================================================================
  // Field layout
  localparam int STATE_LSB      = 0;
  localparam int STATE_MSB      = 1;
  localparam int SEL_LSB        = 2;
  localparam int SEL_MSB_NARROW = 6;
  localparam int SEL_MSB_WIDE   = 7;
  localparam int TRACK_BIT      = 6;

  // ==========================================================================
  // Reset values and masks
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] MASK_NARROW = 8'h7f;
  localparam logic [7:0] MASK_WIDE   = 8'hff;

  // ==========================================================================
  // Voltage coding in millivolts
  localparam logic [4:0]  NARROW_FLOOR_CODE = 5'h02;
  localparam logic [11:0] NARROW_FLOOR_MV   = 12'd1000;
  localparam logic [11:0] NARROW_STEP_MV    = 12'd100;
  localparam logic [4:0]  NARROW_MAX_CODE   = 5'h19;
  localparam logic [11:0] WIDE_BASE_MV      = 12'd800;
  localparam logic [11:0] WIDE_STEP_MV      = 12'd50;
  localparam logic [5:0]  WIDE_MAX_CODE     = 6'h32;
  localparam logic [11:0] MAX_MV            = 12'd3300;

  typedef enum logic [1:0] {
    LRC_OFF    = 2'b00,
    LRC_ACTIVE = 2'b01,
    LRC_SLEEP  = 2'b11
  } lrc_state_t;

endpackage : lrc_pkg

// ---- hw/lrc_decode.sv ----
// Decoder from one control register value to supply state and output voltage.
`timescale 1ns/1ns
module lrc_decode #(
  parameter bit WIDE = 1'b0
) (
  input  wire logic [7:0]  reg_value,
  output logic             enabled,
  output logic             low_power,
  output logic [11:0]      millivolts
);

  // ==========================================================================
  // Supply state
  wire logic [1:0] state_bits = reg_value[lrc_pkg::STATE_MSB:lrc_pkg::STATE_LSB];
  assign enabled   = state_bits[0];
  assign low_power = (state_bits == lrc_pkg::LRC_SLEEP);

  // ==========================================================================
  // Voltage
  function automatic logic [11:0] narrow_mv(input logic [4:0] code);
    logic [4:0] c;
    c = (code < lrc_pkg::NARROW_FLOOR_CODE) ? lrc_pkg::NARROW_FLOOR_CODE : code;
    if (code > lrc_pkg::NARROW_MAX_CODE) begin
      narrow_mv = lrc_pkg::MAX_MV;
    end else begin
      narrow_mv = 12'(lrc_pkg::NARROW_FLOOR_MV
                + 12'(c - lrc_pkg::NARROW_FLOOR_CODE) * lrc_pkg::NARROW_STEP_MV);
    end
  endfunction : narrow_mv

  function automatic logic [11:0] wide_mv(input logic [5:0] code);
    // Codes past the top one are not defined; they hold at the top voltage.
    if (code > lrc_pkg::WIDE_MAX_CODE) begin
      wide_mv = lrc_pkg::MAX_MV;
    end else begin
      wide_mv = 12'(lrc_pkg::WIDE_BASE_MV + 12'(code) * lrc_pkg::WIDE_STEP_MV);
    end
  endfunction : wide_mv

  wire logic [4:0] narrow_code = reg_value[lrc_pkg::SEL_MSB_NARROW:lrc_pkg::SEL_LSB];
  wire logic [5:0] wide_code   = reg_value[lrc_pkg::SEL_MSB_WIDE:lrc_pkg::SEL_LSB];
  assign millivolts = WIDE ? wide_mv(wide_code)
                           : narrow_mv(narrow_code);

endmodule : lrc_decode

// ---- hw/lrc_regs.sv ----
// Control register bank for five linear regulators with decoded outputs.
`timescale 1ns/1ns
module lrc_regs (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        boot_load,
  input  wire logic [39:0] boot_values,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             reg_hit,
  input  wire logic [7:0]  converter_control,
  input  wire logic        first_core_converter_active,
  input  wire logic [11:0] first_core_converter_mv,
  output logic [4:0]       regulator_enable,
  output logic [4:0]       regulator_low_power,
  output logic [59:0]      regulator_millivolts
);

  // ==========================================================================
  // Storage and address decode
  // Index order: 0 five, 1 eight, 2 seven, 3 six, 4 four.
  logic [7:0] ctrl [lrc_pkg::NUM_REGS];

  function automatic logic [7:0] reg_mask(input int idx);
    reg_mask = (idx == lrc_pkg::NUM_REGS - 1) ? lrc_pkg::MASK_WIDE
                                              : lrc_pkg::MASK_NARROW;
  endfunction : reg_mask

  wire logic [7:0] rel_addr = 8'(reg_addr - lrc_pkg::REG_FIVE_OFS);
  wire logic       in_range = (reg_addr >= lrc_pkg::REG_FIVE_OFS)
                           && (reg_addr <= lrc_pkg::REG_FOUR_OFS);
  wire logic [2:0] sel_idx  = rel_addr[2:0];
  assign reg_hit = in_range;

  // srst is the turn-off reset; the general reset is not connected here.
  genvar gi;
  generate
    for (gi = 0; gi < lrc_pkg::NUM_REGS; gi++) begin : g_reg
      wire logic [7:0] m = reg_mask(gi);
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          ctrl[gi] <= lrc_pkg::REG_RESET;
        end else if (boot_load) begin
          ctrl[gi] <= boot_values[gi*8 +: 8] & m;
        end else if (reg_wr && in_range && sel_idx == 3'(gi)) begin
          ctrl[gi] <= reg_wdata & m;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Read path
  logic [7:0] next_rdata;
  assign next_rdata = in_range ? ctrl[sel_idx] : 8'h00;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= lrc_pkg::REG_RESET;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Decoded outputs
  logic [11:0] raw_mv [lrc_pkg::NUM_REGS];
  logic [4:0]  en_w;
  logic [4:0]  lp_w;
  generate
    for (gi = 0; gi < lrc_pkg::NUM_REGS; gi++) begin : g_dec
      lrc_decode #(
        .WIDE (gi == lrc_pkg::NUM_REGS - 1)
      ) u_dec (
        .reg_value  (ctrl[gi]),
        .enabled    (en_w[gi]),
        .low_power  (lp_w[gi]),
        .millivolts (raw_mv[gi])
      );
    end
  endgenerate

  // Tracking overrides only the voltage; the range limit is software's job.
  wire logic tracking = converter_control[lrc_pkg::TRACK_BIT]
                     && first_core_converter_active;
  wire logic [11:0] four_mv = tracking ? first_core_converter_mv
                                       : raw_mv[lrc_pkg::NUM_REGS-1];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      regulator_enable     <= 5'h0;
      regulator_low_power  <= 5'h0;
      regulator_millivolts <= 60'h0;
    end else begin
      regulator_enable     <= en_w;
      regulator_low_power  <= lp_w;
      regulator_millivolts <= {four_mv, raw_mv[3], raw_mv[2], raw_mv[1], raw_mv[0]};
    end
  end

endmodule : lrc_regs

// ---- verif/lrc_regs_assertions.sv ----
// Assertion checker for the regulator control register bank.
`timescale 1ns/1ns
module lrc_chk (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        boot_load,
  input wire logic [39:0] boot_values,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_hit,
  input wire logic [4:0]  regulator_enable,
  input wire logic [4:0]  regulator_low_power
);
  // ==========================================================================
  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [7:0] wmask;
  // Bit 7 of the narrow registers must never come back on a read.
  assign wmask = reg_wdata & ((reg_addr == 8'h36) ? 8'hff : 8'h7f);
  hit_range_a: assert property (reg_hit == (reg_addr inside {[8'h32:8'h36]}))
    else $error("hit flag wrong");
  unmapped_zero_a: assert property (!reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  reserved_bit_a: assert property (reg_hit && reg_addr != 8'h36 |=> !reg_rdata[7])
    else $error("reserved bit set");
  reset_clear_a: assert property (disable iff (1'b0) srst |=> reg_rdata == 8'h00)
    else $error("reset left data");
  write_back_a: assert property (reg_wr && reg_hit && !boot_load ##1
    !reg_wr && !boot_load && $stable(reg_addr) |=> reg_rdata == $past(wmask, 2))
    else $error("write not read back");
  state_out_a: assert property (reg_wr && reg_addr == 8'h36 && !boot_load ##1
    !reg_wr && !boot_load |=> regulator_enable[4] == $past(reg_wdata[0], 2))
    else $error("enable wrong");
  low_on_a: assert property ((regulator_low_power & ~regulator_enable) == 5'h00)
    else $error("low power while off");
  boot_copy_a: assert property (boot_load ##1 boot_load && reg_addr == 8'h36
    && $stable(boot_values) |=> reg_rdata == $past(boot_values[39:32]))
    else $error("boot value lost");
endmodule : lrc_chk
bind lrc_regs lrc_chk u_chk (.sys_clk, .srst, .boot_load, .boot_values, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rdata, .reg_hit, .regulator_enable, .regulator_low_power);

// ---- verif/tb_lrc_regs.sv ----
// Self-checking testbench for the regulator control register bank.
`timescale 1ns/1ns
module tb_lrc_regs;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        boot_load = 1'b0;
  logic [39:0] boot_values = 40'h00_0000_0000;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_hit;
  logic [7:0]  cc = 8'h00;
  logic        ca = 1'b0;
  logic [11:0] cmv = 12'h000;
  logic [4:0]  en;
  logic [4:0]  lp;
  logic [59:0] mv;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cycles = 0;
  lrc_regs u_dut (.sys_clk, .srst, .boot_load, .boot_values, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .reg_hit, .converter_control(cc), .first_core_converter_active(ca),
    .first_core_converter_mv(cmv), .regulator_enable(en), .regulator_low_power(lp),
    .regulator_millivolts(mv));
  initial forever #4 sys_clk = ~sys_clk;
  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data is registered, so it is taken one edge after the address.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    #1 chk("rdata", {4'h0, reg_rdata}, {4'h0, exp});
    chk("hit", {11'h000, reg_hit}, {11'h000, (a >= 8'h32 && a <= 8'h36)});
  endtask : rd
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // ==========================================================================
  // Tests
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(8'h32 + 8'(i), 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(8'h32 + 8'(i), (i == 4) ? 8'hcb : 8'hff);
      rd(8'h32 + 8'(i), (i == 4) ? 8'hcb : 8'h7f);
    end
    for (int s = 0; s < 4; s++) begin
      wr(8'h36, 8'h10 + 8'(s));
      rd(8'h36, 8'h10 + 8'(s));
      chk("on", {11'h000, en[4]}, 12'(s % 2));
      chk("low", {11'h000, lp[4]}, 12'(s == 3));
    end
    for (logic [5:0] c = 6'h00; c < 6'h1a; c += 6'h01) begin
      wr(8'h33, {1'b0, c[4:0], 2'b01});
      rd(8'h33, {1'b0, c[4:0], 2'b01});
      chk("mv", mv[23:12], (c < 3) ? 12'h3e8 : 12'h3e8 + 12'(c - 6'h02) * 12'h064);
      // Codes below 1 V are only legal for software while tracking is enabled.
      @(posedge sys_clk);
      cc <= (c < 6'h04) ? 8'h40 : 8'h00;
      wr(8'h36, {c, 2'b01});
      rd(8'h36, {c, 2'b01});
      chk("mv4", mv[59:48], 12'h320 + 12'(c) * 12'h032);
    end
    wr(8'h36, 8'hc9);
    rd(8'h36, 8'hc9);
    chk("mv4", mv[59:48], 12'hce4);
    wr(8'h36, 8'h21);
    rd(8'h36, 8'h21);
    @(posedge sys_clk);
    cc  <= 8'h40;
    ca  <= 1'b1;
    cmv <= 12'h4b0;
    repeat (2) @(posedge sys_clk);
    #1 chk("track", mv[59:48], 12'h4b0);
    wr(8'h37, 8'h55);
    rd(8'h37, 8'h00);
    rd(8'h36, 8'h21);
    @(posedge sys_clk);
    cc          <= 8'h00;
    boot_values <= 40'hff_1234_56f8;
    boot_load   <= 1'b1;
    repeat (2) @(posedge sys_clk);
    boot_load <= 1'b0;
    rd(8'h32, 8'h78);
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    rd(8'h36, 8'h00);
    test_done();
  end
endmodule : tb_lrc_regs
